// *** logic/hasp_defs.svh ***
/*
  constants of the hall angle signal path: settings table indices, neutral
  values and timing. assumes inclusion by bare name, definitions only.
*/
`ifndef HASP_DEFS_SVH
`define HASP_DEFS_SVH
// ====================================================================
// settings table indices (channel groups take base + channel 0..2)
`define HASP_NV_TGAIN0 7'h00
`define HASP_NV_TGAIN1 7'h03
`define HASP_NV_TOFF0  7'h06
`define HASP_NV_TOFF1  7'h09
`define HASP_NV_PHASE2 7'h0c
`define HASP_NV_PHASE3 7'h0d
`define HASP_NV_CGAIN  7'h0e
`define HASP_NV_COFF   7'h11
`define HASP_NV_REF0   7'h14
`define HASP_NV_REF1   7'h15
`define HASP_NV_MODULO 7'h16
`define HASP_NV_SPGAIN 7'h17
`define HASP_NV_SPOFF  7'h18
`define HASP_NV_NMULT  7'h19
`define HASP_NV_LINCFG 7'h1a
`define HASP_NV_FILT   7'h1b
`define HASP_NV_SPDCFG 7'h1c
`define HASP_NV_PSI5   7'h1d
`define HASP_NV_LOCK   7'h1e
`define HASP_NV_LIN    7'h1f
`define HASP_NV_LINY   7'h30
`define HASP_NV_DEPTH  66
// ====================================================================
// numeric constants
`define HASP_ONE       16'sh4000
`define HASP_AMP_SHIFT 15
`define HASP_CORDIC_K  32'sh00004dba
`define HASP_SEG120    16'h5555
`define HASP_SEG240    16'haaaa
`define HASP_SPD_SCALE 32'sh00004000
`define HASP_SPD_LO    32'sd1000
`define HASP_SPD_HI    32'sd5000
`define HASP_TEMP_OFF  16'sh0000
`define HASP_TEMP_GAIN 16'sh4000
// ====================================================================
// timing: 8 kSps sample period at 20 MHz
`define HASP_CLK_HZ    20000000
`define HASP_SAMPLE_NS 125000
`define HASP_SAMPLE_CYC (`HASP_SAMPLE_NS / (1000000000 / `HASP_CLK_HZ))
`endif

// *** logic/hasp_pkg.sv ***
/*
  types of the hall angle signal path.
  assumes hasp_defs.svh holds the numbers.
*/
package hasp_pkg;
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0000,
    ST_COMP  = 4'b0001,
    ST_PHASE = 4'b0010,
    ST_CUST  = 4'b0011,
    ST_ANGLE = 4'b0100,
    ST_REF   = 4'b0101,
    ST_MOD   = 4'b0110,
    ST_SP    = 4'b0111,
    ST_LIN   = 4'b1000,
    ST_FILT  = 4'b1001,
    ST_OUT   = 4'b1010
  } hasp_stage_e;
  typedef enum logic [1:0] {
    MOD_NONE = 2'b00,
    MOD_90   = 2'b01,
    MOD_120  = 2'b10,
    MOD_180  = 2'b11
  } hasp_modulo_e;
  typedef enum logic [1:0] {
    BUS_ASYNC = 2'b00,
    BUS_SYNCU = 2'b01,
    BUS_SYNCP = 2'b10,
    BUS_DAISY = 2'b11
  } hasp_bus_e;
endpackage : hasp_pkg

// *** logic/hasp_signal_path.sv ***
/*
  digital conditioning path of a three-channel hall position sensor, from
  converter samples to the position / speed word handed to the psi5 framer.
  assumes converter data and temperature on mclk, a psi5 framer after
  tx_word, and a sync pulse pin from the line receiver.
*/
// Function
// - three converter channels are temperature compensated first
// - junction temperature readable, corrected by factory trim
// - magnitude is sum of compensated channels squared over 32768
// - channels two and three get phase correction, readable
// - angle inputs carry phase, gain and offset corrections, readable
// - angle calculation outputs a readable position
// - angle calculation outputs a separately readable field magnitude
// - reference shift maps configured zero position to zero
// - optional wrap into 90, 120 or 180 degree segments
// - setpoint scaling result readable, feeds linearization
// - optional linearization reduces system non-linearity
// - linearization uses 17 variable or 33 fixed setpoints
// - linearized angle readable
// - final filter stage, filtered angle readable
// - final position reflects all stages and settings
// - position, speed or both handed out for psi5 frames
// - psi5-u, psi5-p and async modes; no daisy chain
// - no ecu-to-sensor command path exists
// - sampling at up to 8 kSps
// - read-only stage results plus programmable settings table
// - after lock settings stay readable but refuse writes
// - raw speed is 16384 times position step over range
`timescale 1ns/1ns
`include "hasp_defs.svh"
module hasp_signal_path (
  input  wire logic               mclk,
  input  wire logic               resetn,
  input  wire logic signed [15:0] adc_ch1,
  input  wire logic signed [15:0] adc_ch2,
  input  wire logic signed [15:0] adc_ch3,
  input  wire logic signed [15:0] temp_raw,
  input  wire logic               sync_pulse_pin,
  input  wire logic               nv_wr_en,
  input  wire logic [6:0]         nv_idx,
  input  wire logic [15:0]        nv_wr_data,
  output logic [15:0]             nv_rd_data,
  output logic                    nv_locked,
  output logic signed [15:0]      junction_temp_value,
  output logic signed [15:0]      temp_compensated_channel_one,
  output logic signed [15:0]      temp_compensated_channel_two,
  output logic signed [15:0]      temp_compensated_channel_three,
  output logic [16:0]             amplitude_value,
  output logic signed [15:0]      phase_fixed_channel_two,
  output logic signed [15:0]      phase_fixed_channel_three,
  output logic signed [15:0]      user_trimmed_channel_one,
  output logic signed [15:0]      user_trimmed_channel_two,
  output logic signed [15:0]      user_trimmed_channel_three,
  output logic [15:0]             angle_value,
  output logic [15:0]             computed_field_magnitude,
  output logic [15:0]             ref_shifted_angle,
  output logic [15:0]             wrapped_angle,
  output logic [15:0]             scaled_angle,
  output logic [15:0]             linearized_angle,
  output logic [15:0]             post_filter_angle,
  output logic [15:0]             final_position,
  output logic signed [15:0]      angle_speed_raw,
  output logic                    sample_done,
  output logic [15:0]             tx_word,
  output logic                    tx_is_speed,
  output logic                    tx_valid,
  output logic [1:0]              bus_mode
);
  // ==================================================================
  // helpers
  function automatic logic signed [15:0] sat16(input logic signed [39:0] v);
    if (v > 40'sd32767) return 16'sh7fff;
    if (v < -40'sd32768) return 16'sh8000;
    return v[15:0];
  endfunction : sat16
  function automatic logic signed [15:0] mulq(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [39:0] p;
    p = 40'(a * b);
    return sat16(p >>> 14);
  endfunction : mulq
  function automatic logic [17:0] sq15(input logic signed [15:0] a);
    logic [31:0] p;
    p = 32'(a * a);
    return 18'(p >> `HASP_AMP_SHIFT);
  endfunction : sq15
  function automatic logic [15:0] atan_step(input logic [3:0] i);
    case (i)
      4'h0: return 16'h2000;
      4'h1: return 16'h12e4;
      4'h2: return 16'h09fb;
      4'h3: return 16'h0511;
      4'h4: return 16'h028b;
      4'h5: return 16'h0146;
      4'h6: return 16'h00a3;
      4'h7: return 16'h0051;
      4'h8: return 16'h0029;
      4'h9: return 16'h0014;
      4'ha: return 16'h000a;
      4'hb: return 16'h0005;
      4'hc: return 16'h0003;
      default: return 16'h0001;
    endcase
  endfunction : atan_step
  function automatic logic [15:0] nv_default(input int i);
    if (i < 3 || (i >= 14 && i < 17) || i == 23) return 16'h4000;
    return 16'h0000;
  endfunction : nv_default
  // ==================================================================
  // settings table, lock and read port
  logic [15:0] nv_mem [`HASP_NV_DEPTH];
  logic        lock_reg;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      for (int i = 0; i < `HASP_NV_DEPTH; i++) nv_mem[i] <= nv_default(i);
    end else if (nv_wr_en && !lock_reg && 32'(nv_idx) < `HASP_NV_DEPTH) begin
      nv_mem[nv_idx] <= nv_wr_data;
    end
  end
  // lock is one-way; only a reset (reprogramming session) reopens it
  always_ff @(posedge mclk) begin
    if (!resetn) lock_reg <= 1'b0;
    else if (nv_wr_en && !lock_reg && nv_idx == `HASP_NV_LOCK && nv_wr_data != 16'h0000) lock_reg <= 1'b1;
  end
  // reads stay open whatever the lock; out-of-range index reads zero
  always_ff @(posedge mclk) begin
    if (!resetn) nv_rd_data <= 16'h0000;
    else nv_rd_data <= (32'(nv_idx) < `HASP_NV_DEPTH) ? nv_mem[nv_idx] : 16'h0000;
  end
  assign nv_locked = lock_reg;
  // ==================================================================
  // sample pacer and stage sequencer
  logic [11:0]         pace_reg;
  logic [3:0]          iter_reg;
  hasp_pkg::hasp_stage_e st_reg;
  always_ff @(posedge mclk) begin
    if (!resetn) pace_reg <= 12'h000;
    else if (pace_reg == 12'(`HASP_SAMPLE_CYC - 1)) pace_reg <= 12'h000;
    else pace_reg <= pace_reg + 12'h001;
  end
  // one stage per cycle, the angle stage 15 cycles, so all results of a sample belong together
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_reg   <= hasp_pkg::ST_IDLE;
      iter_reg <= 4'h0;
    end else begin
      case (st_reg)
        hasp_pkg::ST_IDLE:  if (pace_reg == 12'h000) st_reg <= hasp_pkg::ST_COMP;
        hasp_pkg::ST_COMP:  st_reg <= hasp_pkg::ST_PHASE;
        hasp_pkg::ST_PHASE: st_reg <= hasp_pkg::ST_CUST;
        hasp_pkg::ST_CUST: begin
          st_reg   <= hasp_pkg::ST_ANGLE;
          iter_reg <= 4'hf;
        end
        hasp_pkg::ST_ANGLE: begin
          iter_reg <= iter_reg + 4'h1;
          if (iter_reg == 4'hd) st_reg <= hasp_pkg::ST_REF;
        end
        hasp_pkg::ST_REF:  st_reg <= hasp_pkg::ST_MOD;
        hasp_pkg::ST_MOD:  st_reg <= hasp_pkg::ST_SP;
        hasp_pkg::ST_SP:   st_reg <= hasp_pkg::ST_LIN;
        hasp_pkg::ST_LIN:  st_reg <= hasp_pkg::ST_FILT;
        hasp_pkg::ST_FILT: st_reg <= hasp_pkg::ST_OUT;
        default:           st_reg <= hasp_pkg::ST_IDLE;
      endcase
    end
  end
  // ==================================================================
  // temperature compensation, amplitude, phase and customer trim
  logic signed [15:0] adc [3];
  logic signed [15:0] tc  [3];
  logic signed [15:0] tj;
  assign adc[0] = adc_ch1;
  assign adc[1] = adc_ch2;
  assign adc[2] = adc_ch3;
  assign tj = mulq(temp_raw - `HASP_TEMP_OFF, `HASP_TEMP_GAIN);
  always_comb begin
    for (int c = 0; c < 3; c++) begin
      tc[c] = mulq(adc[c] - (nv_mem[`HASP_NV_TOFF0 + c] + mulq(tj, nv_mem[`HASP_NV_TOFF1 + c])),
                   nv_mem[`HASP_NV_TGAIN0 + c] + mulq(tj, nv_mem[`HASP_NV_TGAIN1 + c]));
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      junction_temp_value            <= 16'sh0000;
      temp_compensated_channel_one   <= 16'sh0000;
      temp_compensated_channel_two   <= 16'sh0000;
      temp_compensated_channel_three <= 16'sh0000;
      amplitude_value                <= 17'h00000;
    end else if (st_reg == hasp_pkg::ST_COMP) begin
      junction_temp_value            <= tj;
      temp_compensated_channel_one   <= tc[0];
      temp_compensated_channel_two   <= tc[1];
      temp_compensated_channel_three <= tc[2];
      amplitude_value                <= 17'(sq15(tc[0]) + sq15(tc[1]) + sq15(tc[2]));
    end
  end
  // phase error of channels two and three is taken relative to channel one
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      phase_fixed_channel_two   <= 16'sh0000;
      phase_fixed_channel_three <= 16'sh0000;
    end else if (st_reg == hasp_pkg::ST_PHASE) begin
      phase_fixed_channel_two   <= temp_compensated_channel_two -
                                   mulq(temp_compensated_channel_one, nv_mem[`HASP_NV_PHASE2]);
      phase_fixed_channel_three <= temp_compensated_channel_three -
                                   mulq(temp_compensated_channel_one, nv_mem[`HASP_NV_PHASE3]);
    end
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      user_trimmed_channel_one   <= 16'sh0000;
      user_trimmed_channel_two   <= 16'sh0000;
      user_trimmed_channel_three <= 16'sh0000;
    end else if (st_reg == hasp_pkg::ST_CUST) begin
      user_trimmed_channel_one   <= sat16(40'(mulq(temp_compensated_channel_one, nv_mem[`HASP_NV_CGAIN]))
                                          + 40'($signed(nv_mem[`HASP_NV_COFF])));
      user_trimmed_channel_two   <= sat16(40'(mulq(phase_fixed_channel_two, nv_mem[`HASP_NV_CGAIN + 1]))
                                          + 40'($signed(nv_mem[`HASP_NV_COFF + 1])));
      user_trimmed_channel_three <= sat16(40'(mulq(phase_fixed_channel_three, nv_mem[`HASP_NV_CGAIN + 2]))
                                          + 40'($signed(nv_mem[`HASP_NV_COFF + 2])));
    end
  end
  // ==================================================================
  // angle: iterative vectoring rotation, channel one as x, two as y
  logic signed [17:0] cx_reg;
  logic signed [17:0] cy_reg;
  logic [15:0]        cz_reg;
  logic [31:0]        mag_w;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      cx_reg <= 18'sh00000;
      cy_reg <= 18'sh00000;
      cz_reg <= 16'h0000;
    end else if (st_reg == hasp_pkg::ST_ANGLE && iter_reg == 4'hf) begin
      // pre-rotate by 180 degrees so iterations only cover +-90
      cx_reg <= user_trimmed_channel_one < 0 ? -18'(user_trimmed_channel_one) : 18'(user_trimmed_channel_one);
      cy_reg <= user_trimmed_channel_one < 0 ? -18'(user_trimmed_channel_two) : 18'(user_trimmed_channel_two);
      cz_reg <= user_trimmed_channel_one < 0 ? 16'h8000 : 16'h0000;
    end else if (st_reg == hasp_pkg::ST_ANGLE) begin
      cx_reg <= cy_reg >= 0 ? cx_reg + (cy_reg >>> iter_reg) : cx_reg - (cy_reg >>> iter_reg);
      cy_reg <= cy_reg >= 0 ? cy_reg - (cx_reg >>> iter_reg) : cy_reg + (cx_reg >>> iter_reg);
      cz_reg <= cy_reg >= 0 ? cz_reg + atan_step(iter_reg) : cz_reg - atan_step(iter_reg);
    end
  end
  assign mag_w = 32'(cx_reg * `HASP_CORDIC_K) >> 15;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      angle_value              <= 16'h0000;
      computed_field_magnitude <= 16'h0000;
    end else if (st_reg == hasp_pkg::ST_REF) begin
      angle_value              <= cz_reg;
      computed_field_magnitude <= mag_w[15:0];
    end
  end
  // ==================================================================
  // reference shift, modulo, setpoint scaling
  logic [15:0] refd;
  logic [15:0] wrapd;
  logic [39:0] spd;
  assign refd = cz_reg - (nv_mem[`HASP_NV_REF0] + mulq(junction_temp_value, nv_mem[`HASP_NV_REF1]));
  always_comb begin
    case (hasp_pkg::hasp_modulo_e'(nv_mem[`HASP_NV_MODULO][1:0]))
      hasp_pkg::MOD_90:  wrapd = {2'b00, ref_shifted_angle[13:0]};
      hasp_pkg::MOD_180: wrapd = {1'b0, ref_shifted_angle[14:0]};
      hasp_pkg::MOD_120: begin
        // 120 degrees is not a power of two share of the circle
        if (ref_shifted_angle >= `HASP_SEG240) wrapd = ref_shifted_angle - `HASP_SEG240;
        else if (ref_shifted_angle >= `HASP_SEG120) wrapd = ref_shifted_angle - `HASP_SEG120;
        else wrapd = ref_shifted_angle;
      end
      default: wrapd = ref_shifted_angle;
    endcase
  end
  assign spd = 40'((($signed({1'b0, wrapped_angle}) - $signed({1'b0, nv_mem[`HASP_NV_SPOFF]})) *
                    $signed(nv_mem[`HASP_NV_SPGAIN])) <<< nv_mem[`HASP_NV_NMULT][2:0]) >>> 14;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      ref_shifted_angle <= 16'h0000;
      wrapped_angle     <= 16'h0000;
      scaled_angle      <= 16'h0000;
    end else begin
      if (st_reg == hasp_pkg::ST_REF) ref_shifted_angle <= refd;
      if (st_reg == hasp_pkg::ST_MOD) wrapped_angle <= wrapd;
      // unsigned clamp: the linearization input range is 0..ffff
      if (st_reg == hasp_pkg::ST_SP) scaled_angle <= $signed(spd) < 0 ? 16'h0000 :
                                                       (spd > 40'hffff ? 16'hffff : spd[15:0]);
    end
  end
  // ==================================================================
  // linearization: fixed grid of 33 points or 17 free x/y pairs
  logic [15:0]        lx0;
  logic [15:0]        lx1;
  logic [15:0]        ly0;
  logic [15:0]        ly1;
  logic [4:0]         seg;
  logic signed [39:0] lin_w;
  always_comb begin
    seg = 5'h00;
    if (nv_mem[`HASP_NV_LINCFG][1]) begin
      for (int k = 1; k < 16; k++) if (scaled_angle >= nv_mem[`HASP_NV_LIN + k]) seg = 5'(k);
      lx0 = nv_mem[`HASP_NV_LIN + seg];
      lx1 = nv_mem[`HASP_NV_LIN + seg + 1];
      ly0 = nv_mem[`HASP_NV_LINY + seg];
      ly1 = nv_mem[`HASP_NV_LINY + seg + 1];
    end else begin
      seg = scaled_angle[15:11];
      lx0 = {seg, 11'h000};
      lx1 = lx0 + 16'h0800;
      ly0 = nv_mem[`HASP_NV_LIN + seg];
      ly1 = nv_mem[`HASP_NV_LIN + seg + 1];
    end
    // the divide only serves free points; a zero-width segment gives y0
    if (nv_mem[`HASP_NV_LINCFG][1] && lx1 > lx0)
      lin_w = 40'($signed({1'b0, ly0})) + 40'(($signed({1'b0, ly1}) - $signed({1'b0, ly0})) *
              $signed({1'b0, scaled_angle - lx0}) / $signed({1'b0, lx1 - lx0}));
    else if (nv_mem[`HASP_NV_LINCFG][1])
      lin_w = 40'({1'b0, ly0});
    else
      lin_w = 40'($signed({1'b0, ly0})) + 40'((($signed({1'b0, ly1}) - $signed({1'b0, ly0})) *
              $signed({1'b0, scaled_angle[10:0]})) >>> 11);
  end
  always_ff @(posedge mclk) begin
    if (!resetn) linearized_angle <= 16'h0000;
    else if (st_reg == hasp_pkg::ST_LIN)
      linearized_angle <= !nv_mem[`HASP_NV_LINCFG][0] ? scaled_angle :
                          (lin_w < 0 ? 16'h0000 : (lin_w > 40'sh0ffff ? 16'hffff : lin_w[15:0]));
  end
  // ==================================================================
  // final filter, output and speed
  logic signed [17:0] fdiff;
  logic signed [15:0] pdiff;
  assign fdiff = $signed({2'b00, linearized_angle}) - $signed({2'b00, post_filter_angle});
  assign pdiff = post_filter_angle - final_position;
  // first-order low pass; shift 0 bypasses. does not follow the 360 wrap
  always_ff @(posedge mclk) begin
    if (!resetn) post_filter_angle <= 16'h0000;
    else if (st_reg == hasp_pkg::ST_FILT)
      post_filter_angle <= post_filter_angle + 16'(fdiff >>> nv_mem[`HASP_NV_FILT][3:0]);
  end
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      final_position  <= 16'h0000;
      angle_speed_raw <= 16'sh0000;
      sample_done     <= 1'b0;
    end else begin
      sample_done <= st_reg == hasp_pkg::ST_OUT;
      if (st_reg == hasp_pkg::ST_OUT) begin
        final_position  <= post_filter_angle;
        angle_speed_raw <= sat16(40'(32'(pdiff) * `HASP_SPD_SCALE /
                                 (nv_mem[`HASP_NV_SPDCFG][0] ? `HASP_SPD_HI : `HASP_SPD_LO)));
      end
    end
  end
  // ==================================================================
  // psi5 word hand-off; the sync pin is the only input from the line
  logic      sync_s1_reg;
  logic      sync_s2_reg;
  logic      sync_s3_reg;
  logic      alt_reg;
  logic      fire;
  hasp_pkg::hasp_bus_e mode_w;
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync_s1_reg <= 1'b0;
      sync_s2_reg <= 1'b0;
      sync_s3_reg <= 1'b0;
    end else begin
      sync_s1_reg <= sync_pulse_pin;
      sync_s2_reg <= sync_s1_reg;
      sync_s3_reg <= sync_s2_reg;
    end
  end
  // daisy chain code is not supported and falls back to async
  assign mode_w = nv_mem[`HASP_NV_PSI5][1:0] == hasp_pkg::BUS_DAISY ? hasp_pkg::BUS_ASYNC :
                  hasp_pkg::hasp_bus_e'(nv_mem[`HASP_NV_PSI5][1:0]);
  assign fire = mode_w == hasp_pkg::BUS_ASYNC ? sample_done : (sync_s2_reg && !sync_s3_reg);
  // no receive path: sync edges only time frames, never carry commands
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      tx_word     <= 16'h0000;
      tx_is_speed <= 1'b0;
      tx_valid    <= 1'b0;
      alt_reg     <= 1'b0;
      bus_mode    <= 2'b00;
    end else begin
      bus_mode <= mode_w;
      tx_valid <= fire;
      if (fire) begin
        alt_reg     <= !alt_reg;
        tx_is_speed <= nv_mem[`HASP_NV_PSI5][3:2] == 2'b01 || (nv_mem[`HASP_NV_PSI5][3:2] == 2'b10 && alt_reg);
        tx_word     <= (nv_mem[`HASP_NV_PSI5][3:2] == 2'b01 || (nv_mem[`HASP_NV_PSI5][3:2] == 2'b10 && alt_reg))
                       ? angle_speed_raw : final_position;
      end
    end
  end
endmodule : hasp_signal_path

// *** test/hasp_host_model.sv ***
/* host side model: sends sync pulses when enabled and counts words.
   assumes tx_valid pulses one mclk cycle per word. */
`timescale 1ns/1ns
module hasp_host_model (
  input  wire logic mclk,
  input  wire logic resetn,
  input  wire logic sync_en,
  input  wire logic tx_valid,
  output logic      sync_pulse_pin,
  output logic [7:0] frames
);
  logic [11:0] tick_reg;
  // =========================================
  // 4-cycle pulse every 3000 cycles, wide enough for two sync flops; nothing else goes back
  always_ff @(posedge mclk) begin
    tick_reg <= (!resetn || tick_reg == 12'hbb7) ? 12'h000 : tick_reg + 12'h001;
    sync_pulse_pin <= sync_en && tick_reg < 12'h004;
  end
  // words received
  always_ff @(posedge mclk) begin
    if (!resetn) frames <= 8'h00;
    else if (tx_valid) frames <= frames + 8'h01;
  end
endmodule : hasp_host_model

// *** test/hasp_sva.sv ***
/* port checker of the signal path.
   assumes a bind onto hasp_signal_path and one clock domain. */
`timescale 1ns/1ns
module hasp_sva (
  input wire logic               mclk,
  input wire logic               resetn,
  input wire logic [6:0]         nv_idx,
  input wire logic [15:0]        nv_rd_data,
  input wire logic               nv_locked,
  input wire logic signed [15:0] temp_compensated_channel_one,
  input wire logic signed [15:0] temp_compensated_channel_two,
  input wire logic signed [15:0] temp_compensated_channel_three,
  input wire logic [16:0]        amplitude_value,
  input wire logic [15:0]        final_position,
  input wire logic               sample_done,
  input wire logic [15:0]        tx_word,
  input wire logic               tx_is_speed,
  input wire logic               tx_valid,
  input wire logic [1:0]         bus_mode
);
  // =========================================
  // expected magnitude: each square floored before the sum
  logic signed [31:0] sq1, sq2, sq3;
  logic [16:0]        amp_exp;
  assign sq1 = temp_compensated_channel_one * temp_compensated_channel_one;
  assign sq2 = temp_compensated_channel_two * temp_compensated_channel_two;
  assign sq3 = temp_compensated_channel_three * temp_compensated_channel_three;
  assign amp_exp = 17'(sq1 >>> 15) + 17'(sq2 >>> 15) + 17'(sq3 >>> 15);
  // =========================================
  // properties, all on mclk
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_done_pulse_gap: assert property (sample_done |=> !sample_done [*8]) else $error("done too close");
  a_tx_pulse_one: assert property (tx_valid |=> !tx_valid) else $error("tx valid too long");
  a_async_tx_fire: assert property (sample_done && bus_mode == 2'h0 |=> tx_valid) else $error("no tx");
  a_tx_word_pos: assert property (sample_done && !bus_mode |=> tx_is_speed || tx_word == final_position)
    else $error("tx word wrong");
  a_no_daisy_mode: assert property (bus_mode != 2'h3) else $error("daisy mode shown");
  a_amp_sum: assert property (sample_done |-> amplitude_value == amp_exp) else $error("magnitude wrong");
  a_lock_sticky: assert property (nv_locked |=> nv_locked) else $error("lock dropped");
  a_lock_read_hold: assert property (nv_locked && $past(nv_locked) && $stable(nv_idx) |=> $stable(nv_rd_data))
    else $error("locked table changed");
  c_sample: cover property (sample_done);
  c_speed: cover property (tx_valid && tx_is_speed);
  c_lock: cover property ($rose(nv_locked));
endmodule : hasp_sva
bind hasp_signal_path hasp_sva sva_u (.*);

// *** test/test_hall_angle_signal_path.sv ***
/* self-checking bench of the signal path with the host model.
   assumes default settings after reset and a 2500-cycle sample pace. */
`timescale 1ns/1ns
module test_hall_angle_signal_path;
  logic mclk = 1'b0, resetn = 1'b0, nv_wr_en = 1'b0, sync_en = 1'b0;
  logic sync_pulse_pin, nv_locked, sample_done, tx_is_speed, tx_valid;
  logic signed [15:0] adc_ch1 = 0, adc_ch2 = 0, adc_ch3 = 0, temp_raw = 16'sh0123, junction_temp_value;
  logic signed [15:0] temp_compensated_channel_one, temp_compensated_channel_two, temp_compensated_channel_three;
  logic signed [15:0] phase_fixed_channel_two, phase_fixed_channel_three, user_trimmed_channel_one;
  logic signed [15:0] user_trimmed_channel_two, user_trimmed_channel_three, angle_speed_raw;
  logic [15:0] nv_wr_data = 0, nv_rd_data, angle_value, computed_field_magnitude, ref_shifted_angle, wrapped_angle;
  logic [15:0] scaled_angle, linearized_angle, post_filter_angle, final_position, tx_word, rd;
  logic [16:0] amplitude_value;
  logic [6:0]  nv_idx = 0;
  logic [7:0]  frames, f0;
  logic [1:0]  bus_mode;
  int          err_total = 0, n_tests = 0, cycles = 0;
  hasp_signal_path dut_u (.*);
  hasp_host_model host_u (.mclk(mclk), .resetn(resetn), .sync_en(sync_en), .tx_valid(tx_valid),
    .sync_pulse_pin(sync_pulse_pin), .frames(frames));
  // =========================================
  // clock and hang guard, ceiling well above the planned run
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 45000) begin
      err_total++;
      print_verdict();
    end
  end
  // =========================================
  // shared tasks
  task automatic check(input logic [16:0] seen, input logic [16:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic nv_write(input logic [6:0] i, input logic [15:0] d);
    @(posedge mclk);
    nv_idx <= i;
    nv_wr_data <= d;
    nv_wr_en <= 1'b1;
    @(posedge mclk);
    nv_wr_en <= 1'b0;
  endtask : nv_write
  task automatic nv_read(input logic [6:0] i);
    @(posedge mclk);
    nv_idx <= i;
    repeat (2) @(posedge mclk);
    #1 rd = nv_rd_data;
  endtask : nv_read
  // bounded wait for the next finished sample
  task automatic wait_done();
    int k;
    @(posedge mclk) #1;
    for (k = 0; k < 3000 && sample_done !== 1'b1; k++) @(posedge mclk) #1;
  endtask : wait_done
  // =========================================
  // scenarios
  task automatic t_reset_table();
    nv_read(7'h00);
    check(rd, 16'h4000);
    nv_read(7'h46);
    check(rd, 16'h0000);
    check(nv_locked, 1'b0);
  endtask : t_reset_table
  task automatic t_channels();
    adc_ch1 <= 16'sh2000;
    adc_ch2 <= 16'sh1000;
    adc_ch3 <= -16'sh1000;
    repeat (3) wait_done();
    check(junction_temp_value, 16'h0123);
    check(temp_compensated_channel_one, 16'h2000);
    check(temp_compensated_channel_three[15:0], 16'hf000);
    check(amplitude_value, 17'h00c00);
    check(computed_field_magnitude > 16'h2300 && computed_field_magnitude < 16'h2400, 1'b1);
    check(phase_fixed_channel_two, 16'h1000);
    check(user_trimmed_channel_three[15:0], 16'hf000);
    check(angle_speed_raw, 16'h0000);
    @(posedge mclk) #1;
    check(tx_valid, 1'b1);
    check(tx_word, final_position);
  endtask : t_channels
  task automatic t_modulo();
    logic [15:0] lim [1:3] = '{16'h4000, 16'h5555, 16'h8000};
    adc_ch1 <= -16'sh2000;
    adc_ch2 <= -16'sh1000;
    repeat (2) wait_done();
    check(angle_value >= 16'h8000, 1'b1);
    check(ref_shifted_angle, angle_value);
    for (int m = 1; m <= 3; m++) begin
      nv_write(7'h16, 16'(m));
      repeat (2) wait_done();
      check(wrapped_angle < lim[m], 1'b1);
    end
    nv_write(7'h16, 16'h0000);
  endtask : t_modulo
  task automatic t_speed_word();
    nv_write(7'h1d, 16'h0004);
    wait_done();
    @(posedge mclk) #1;
    check({tx_valid, tx_is_speed}, 2'b11);
    nv_write(7'h1d, 16'h0000);
  endtask : t_speed_word
  task automatic t_bus_modes();
    sync_en <= 1'b1;
    nv_write(7'h1d, 16'h0001);
    f0 = frames;
    repeat (3200) @(posedge mclk);
    #1 check(bus_mode, 2'h1);
    check(frames != f0, 1'b1);
    nv_write(7'h1d, 16'h0003);
    repeat (3) @(posedge mclk);
    #1 check(bus_mode == 2'h3, 1'b0);
    sync_en <= 1'b0;
    nv_write(7'h1d, 16'h0000);
  endtask : t_bus_modes
  task automatic t_lock();
    nv_write(7'h28, 16'h1234);
    nv_read(7'h28);
    check(rd, 16'h1234);
    nv_write(7'h1e, 16'h0001);
    nv_write(7'h28, 16'h5678);
    nv_read(7'h28);
    check(rd, 16'h1234);
    check(nv_locked, 1'b1);
  endtask : t_lock
  task automatic print_verdict();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict
  // =========================================
  // main sequence
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    t_reset_table();
    t_channels();
    t_modulo();
    t_speed_word();
    t_bus_modes();
    t_lock();
    print_verdict();
  end
endmodule : test_hall_angle_signal_path
